// >>> hpllc_top.sv
// Top: register file and control of the high-speed PLL core
`timescale 1ns/10ps
module hpllc_top
    import hpllc_pkg::*;
#(
    parameter int LOCK_WAIT = LOCK_WAIT_CYC
)
(
    // Clock, reset, enable
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    output logic [31:0]      rd_data_o,
    // Analog core status
    input  wire logic        lock_i,
    // Analog core controls
    output logic [3:0]       pll_input_source_o,
    output logic [9:0]       pre_divider_code_o,
    output logic [16:0]      multiplier_code_o,
    output logic [6:0]       post_divider_code_o,
    output logic [3:0]       r_bandwidth_o,
    output logic [3:0]       i_bandwidth_o,
    output logic [4:0]       p_bandwidth_o,
    output logic             output_clock_gate_o,
    output logic             pll_power_off_o,
    output logic             pre_divider_bypass_o,
    output logic             hold_rate_open_loop_o,
    // Interrupt
    output logic             irq_o
);
    hpllc_state_t st_reg;
    hpllc_state_t st_next;

    logic [2:0] ack;
    logic [2:0] load;
    logic [3:0] evt;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic       irq_clr;
    logic       irq_mask_wr;
    logic       lock_now;
    logic       open_now;
    logic       waiting;

    // Address match shared by the write and read decoders
    function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
        hit = (a == off);
    endfunction

    // One handshake per request bit: multiplier/bandwidth, pre, post
    for (genvar g = 0; g < 3; g++) begin : g_hs
        hpllc_rate_hs u_hs (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .ce_i      (ce_i),
            .req_i     (st_reg.req[g]),
            .ack_o     (ack[g]),
            .load_o    (load[g])
        );
    end

    // Interrupt status is cleared by reading it
    assign irq_clr = ce_i && rd_en_i && hit(addr_i, ADR_IRQ_ST);
    assign irq_mask_wr = wr_en_i && hit(addr_i, ADR_IRQ_MK);

    hpllc_irq u_irq (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .evt_i     (evt),
        .mask_wr_i (irq_mask_wr),
        .mask_i    (wr_data_i[3:0]),
        .clr_i     (irq_clr),
        .status_o  (irq_status),
        .mask_o    (irq_mask),
        .irq_o     (irq_o)
    );

    // Live core state; a powered-down core reports neither lock nor free run
    assign lock_now = lock_i && !st_reg.mode[MODE_POWER_OFF];
    assign open_now = st_reg.mode[MODE_OPEN_LOOP] && !st_reg.mode[MODE_POWER_OFF];
    assign waiting = !st_reg.mode[MODE_POWER_OFF] && !lock_now && !open_now;

    // Next state of the register block
    always_comb begin
        st_next = st_reg;
        evt = 4'h0;
        if (ce_i) begin
            // Register writes; reserved bits are dropped
            if (wr_en_i) begin
                if (hit(addr_i, ADR_SRC)) begin
                    st_next.src = wr_data_i[3:0];
                end
                if (hit(addr_i, ADR_PRE)) begin
                    st_next.pre = wr_data_i[9:0];
                end
                if (hit(addr_i, ADR_MUL)) begin
                    st_next.mul = wr_data_i[16:0];
                end
                if (hit(addr_i, ADR_POST)) begin
                    st_next.post = wr_data_i[6:0];
                end
                if (hit(addr_i, ADR_MODE)) begin
                    st_next.mode = wr_data_i[5:0] & MODE_WMASK;
                end
                if (hit(addr_i, ADR_REQ)) begin
                    st_next.req = wr_data_i[2:0];
                end
                if (hit(addr_i, ADR_R_BW)) begin
                    st_next.r_bw = wr_data_i[3:0];
                end
                if (hit(addr_i, ADR_I_BW)) begin
                    st_next.i_bw = wr_data_i[3:0];
                end
                if (hit(addr_i, ADR_P_BW)) begin
                    st_next.p_bw = wr_data_i[4:0];
                end
            end

            // Codes reach the core directly while it is off; when running,
            // only through the handshake so the loop never sees a half update
            if (st_reg.mode[MODE_POWER_OFF]) begin
                st_next.pre_app = st_reg.pre;
                st_next.mul_app = st_reg.mul;
                st_next.post_app = st_reg.post;
                st_next.r_app = st_reg.r_bw;
                st_next.i_app = st_reg.i_bw;
                st_next.p_app = st_reg.p_bw;
            end else begin
                if (load[REQ_MUL]) begin
                    st_next.mul_app = st_reg.mul;
                    st_next.r_app = st_reg.r_bw;
                    st_next.i_app = st_reg.i_bw;
                    st_next.p_app = st_reg.p_bw;
                end
                if (load[REQ_PRE]) begin
                    st_next.pre_app = st_reg.pre;
                end
                if (load[REQ_POST]) begin
                    st_next.post_app = st_reg.post;
                end
            end

            // Status bits and their edges
            st_next.stat[STAT_LOCK] = lock_now;
            st_next.stat[STAT_OPEN] = open_now;
            evt[IRQ_LOCK_GAIN] = lock_now && !st_reg.stat[STAT_LOCK];
            evt[IRQ_LOCK_LOST] = !lock_now && st_reg.stat[STAT_LOCK];
            evt[IRQ_RATE_DONE] = |load;

            // Lock wait limit: one event per unlocked stretch
            if (!waiting) begin
                st_next.tmo_cnt = '0;
                st_next.tmo_done = 1'b0;
            end else if (!st_reg.tmo_done) begin
                if (st_reg.tmo_cnt == TMO_W'(LOCK_WAIT - 1)) begin
                    st_next.tmo_done = 1'b1;
                    evt[IRQ_LOCK_TMO] = 1'b1;
                end else begin
                    st_next.tmo_cnt = st_reg.tmo_cnt + TMO_W'(1);
                end
            end

            // Read data stand only in the cycle after the strobe;
            // reserved bits and unmapped addresses read as zero
            st_next.rdata = 32'h0;
            if (rd_en_i) begin
                if (hit(addr_i, ADR_SRC)) begin
                    st_next.rdata = {28'h0, st_reg.src};
                end
                if (hit(addr_i, ADR_PRE)) begin
                    st_next.rdata = {22'h0, st_reg.pre};
                end
                if (hit(addr_i, ADR_MUL)) begin
                    st_next.rdata = {15'h0, st_reg.mul};
                end
                if (hit(addr_i, ADR_POST)) begin
                    st_next.rdata = {25'h0, st_reg.post};
                end
                if (hit(addr_i, ADR_MODE)) begin
                    st_next.rdata = {26'h0, st_reg.mode};
                end
                if (hit(addr_i, ADR_STATE)) begin
                    st_next.rdata = {30'h0, st_reg.stat};
                end
                if (hit(addr_i, ADR_ACK)) begin
                    st_next.rdata = {29'h0, ack};
                end
                if (hit(addr_i, ADR_REQ)) begin
                    st_next.rdata = {29'h0, st_reg.req};
                end
                if (hit(addr_i, ADR_R_BW)) begin
                    st_next.rdata = {28'h0, st_reg.r_bw};
                end
                if (hit(addr_i, ADR_I_BW)) begin
                    st_next.rdata = {28'h0, st_reg.i_bw};
                end
                if (hit(addr_i, ADR_P_BW)) begin
                    st_next.rdata = {27'h0, st_reg.p_bw};
                end
                if (hit(addr_i, ADR_IRQ_ST)) begin
                    st_next.rdata = {28'h0, irq_status};
                end
                if (hit(addr_i, ADR_IRQ_MK)) begin
                    st_next.rdata = {28'h0, irq_mask};
                end
            end
        end
    end

    // State register; the core starts powered down on the fast oscillator
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.src <= SRC_FAST_OSC;
            st_reg.mode <= MODE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Core controls, all from flip-flops
    assign pll_input_source_o = st_reg.src;
    assign pre_divider_code_o = st_reg.pre_app;
    assign multiplier_code_o = st_reg.mul_app;
    assign post_divider_code_o = st_reg.post_app;
    assign r_bandwidth_o = st_reg.r_app;
    assign i_bandwidth_o = st_reg.i_app;
    assign p_bandwidth_o = st_reg.p_app;
    assign output_clock_gate_o = st_reg.mode[MODE_CLK_GATE];
    assign pll_power_off_o = st_reg.mode[MODE_POWER_OFF];
    assign pre_divider_bypass_o = st_reg.mode[MODE_BYPASS];
    assign hold_rate_open_loop_o = st_reg.mode[MODE_OPEN_LOOP];
    assign rd_data_o = st_reg.rdata;

    // Checks on the block's own behaviour
    property p_mode_write;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_en_i && addr_i == ADR_MODE) |=>
            output_clock_gate_o == $past(wr_data_i[0])
            && pll_power_off_o == $past(wr_data_i[2])
            && pre_divider_bypass_o == $past(wr_data_i[4])
            && hold_rate_open_loop_o == $past(wr_data_i[5]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode bits not applied");

    // Lock is registered once, so it must stand a cycle before the read
    property p_read_lock;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && lock_i && !pll_power_off_o) ##1 (ce_i && rd_en_i && addr_i == ADR_STATE)
            |=> rd_data_o[0];
    endproperty
    a_read_lock: assert property (p_read_lock) else $error("lock not reported");

    property p_read_once;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !rd_en_i) |=> rd_data_o == 32'h0;
    endproperty
    a_read_once: assert property (p_read_once) else $error("read data held too long");

    property p_open_stat;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && $past(ce_i) && rd_en_i && addr_i == ADR_STATE) |=>
            rd_data_o[1] == ($past(hold_rate_open_loop_o, 2) && !$past(pll_power_off_o, 2));
    endproperty
    a_open_stat: assert property (p_open_stat) else $error("free-run status wrong");

    property p_off_follow;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && pll_power_off_o && !(wr_en_i && addr_i == ADR_MUL)) ##1 ce_i
            |-> ##1 multiplier_code_o == $past(st_reg.mul);
    endproperty
    a_off_follow: assert property (p_off_follow) else $error("code not passed while off");

    property p_ack_read;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_en_i && addr_i == ADR_ACK) |=> rd_data_o[2:0] == $past(ack);
    endproperty
    a_ack_read: assert property (p_ack_read) else $error("ack read mismatch");

    property p_src_write;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_en_i && addr_i == ADR_SRC) |=> pll_input_source_o == $past(wr_data_i[3:0]);
    endproperty
    a_src_write: assert property (p_src_write) else $error("source not stored");

    // Running codes move only through the handshake, never straight from a write
    property p_run_hold_mul;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !pll_power_off_o && !load[REQ_MUL]) |=> $stable(multiplier_code_o);
    endproperty
    a_run_hold_mul: assert property (p_run_hold_mul) else $error("multiplier moved");

    property p_run_hold_pre;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !pll_power_off_o && !load[REQ_PRE]) |=> $stable(pre_divider_code_o);
    endproperty
    a_run_hold_pre: assert property (p_run_hold_pre) else $error("pre divider moved");

    property p_run_hold_post;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !pll_power_off_o && !load[REQ_POST]) |=> $stable(post_divider_code_o);
    endproperty
    a_run_hold_post: assert property (p_run_hold_post) else $error("post divider moved");

    // A powered-down core reports neither lock nor free run
    property p_off_stat;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && $past(ce_i) && $past(pll_power_off_o) && rd_en_i && addr_i == ADR_STATE)
            |=> rd_data_o[1:0] == 2'h0;
    endproperty
    a_off_stat: assert property (p_off_stat) else $error("status set while off");

    // Lock gain and the lock wait limit both raise their status bits
    property p_lock_gain;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && lock_now && !st_reg.stat[STAT_LOCK]) |=> irq_status[IRQ_LOCK_GAIN];
    endproperty
    a_lock_gain: assert property (p_lock_gain) else $error("lock gain not flagged");

    property p_tmo_event;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && waiting && !st_reg.tmo_done && st_reg.tmo_cnt == TMO_W'(LOCK_WAIT - 1))
            |=> irq_status[IRQ_LOCK_TMO];
    endproperty
    a_tmo_event: assert property (p_tmo_event) else $error("lock wait not flagged");
endmodule

// >>> hpllc_pkg.sv
// Package: register map, field layout, reset values and timing of the PLL control block
package hpllc_pkg;
    // Register byte addresses
    localparam logic [31:0] ADR_SRC    = 32'h8000_4cac;
    localparam logic [31:0] ADR_MUL    = 32'h8000_4cb0;
    localparam logic [31:0] ADR_PRE    = 32'h8000_4cb4;
    localparam logic [31:0] ADR_POST   = 32'h8000_4cb8;
    localparam logic [31:0] ADR_MODE   = 32'h8000_4cbc;
    localparam logic [31:0] ADR_STATE  = 32'h8000_4cc0;
    localparam logic [31:0] ADR_ACK    = 32'h8000_4cc4;
    localparam logic [31:0] ADR_REQ    = 32'h8000_4cc8;
    localparam logic [31:0] ADR_R_BW   = 32'h8000_4cd8;
    localparam logic [31:0] ADR_I_BW   = 32'h8000_4cdc;
    localparam logic [31:0] ADR_P_BW   = 32'h8000_4ce0;
    localparam logic [31:0] ADR_IRQ_ST = 32'h8000_4ce4;
    localparam logic [31:0] ADR_IRQ_MK = 32'h8000_4ce8;
    // Input source encodings
    localparam logic [3:0] SRC_FAST_OSC = 4'h1;
    localparam logic [3:0] SRC_MCLK_PIN = 4'h2;
    localparam logic [3:0] SRC_BCLK_PIN = 4'h3;
    localparam logic [3:0] SRC_WS_PIN   = 4'h4;
    localparam logic [3:0] SRC_MAIN_PLL = 4'h8;
    // Mode bit positions and reset value
    localparam int MODE_CLK_GATE = 0;
    localparam int MODE_POWER_OFF = 2;
    localparam int MODE_BYPASS = 4;
    localparam int MODE_OPEN_LOOP = 5;
    localparam logic [5:0] MODE_RESET = 6'h04;
    localparam logic [5:0] MODE_WMASK = 6'h35;
    // Status, request and interrupt bit positions
    localparam int STAT_LOCK = 0;
    localparam int STAT_OPEN = 1;
    localparam int REQ_MUL = 0;
    localparam int REQ_PRE = 1;
    localparam int REQ_POST = 2;
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOST = 1;
    localparam int IRQ_RATE_DONE = 2;
    localparam int IRQ_LOCK_TMO = 3;
    // Timing at the 100 MHz register clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 40;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_WAIT_US = 500;
    localparam int LOCK_WAIT_CYC = LOCK_WAIT_US * 1000 / CLK_PERIOD_NS;
    localparam int TMO_W = 20;
    // State of the top-level register block
    typedef struct packed {
        logic [3:0]       src;
        logic [9:0]       pre;
        logic [16:0]      mul;
        logic [6:0]       post;
        logic [5:0]       mode;
        logic [2:0]       req;
        logic [3:0]       r_bw;
        logic [3:0]       i_bw;
        logic [4:0]       p_bw;
        logic [9:0]       pre_app;
        logic [16:0]      mul_app;
        logic [6:0]       post_app;
        logic [3:0]       r_app;
        logic [3:0]       i_app;
        logic [4:0]       p_app;
        logic [1:0]       stat;
        logic [TMO_W-1:0] tmo_cnt;
        logic             tmo_done;
        logic [31:0]      rdata;
    } hpllc_state_t;
endpackage

// >>> hpllc_rate_hs.sv
// Rate-change request/acknowledge handshake for one request bit
`timescale 1ns/10ps
module hpllc_rate_hs
    import hpllc_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Handshake
    input  wire logic req_i,
    output logic      ack_o,
    output logic      load_o
);
    typedef struct packed {
        logic       ack;
        logic [2:0] cnt;
    } hpllc_hs_t;
    hpllc_hs_t hs_reg;
    hpllc_hs_t hs_next;

    // Ack copies the request after a settle time; codes load as ack rises
    always_comb begin
        hs_next = hs_reg;
        load_o = 1'b0;
        if (ce_i) begin
            if (hs_reg.cnt == 3'h0) begin
                if (req_i != hs_reg.ack) hs_next.cnt = 3'(SETTLE_CYC);
            end else begin
                hs_next.cnt = hs_reg.cnt - 3'h1;
                if (hs_reg.cnt == 3'h1) begin
                    hs_next.ack = req_i;
                    load_o = req_i;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) hs_reg <= '0;
        else hs_reg <= hs_next;
    end

    assign ack_o = hs_reg.ack;

    property p_ack_delay;
        @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
        ($rose(req_i) && !ack_o && hs_reg.cnt == 3'h0) |-> !ack_o[*5] ##1 ack_o;
    endproperty
    a_ack_delay: assert property (p_ack_delay) else $error("ack not set 5 cycles after request");

    property p_load_ack;
        @(posedge clk_sys_i) disable iff (rst_i)
        load_o |=> ack_o;
    endproperty
    a_load_ack: assert property (p_load_ack) else $error("load without ack");
endmodule

// >>> hpllc_irq.sv
// Sticky interrupt status with mask and clear on read
`timescale 1ns/10ps
module hpllc_irq
    import hpllc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Events and software access
    input  wire logic [3:0] evt_i,
    input  wire logic       mask_wr_i,
    input  wire logic [3:0] mask_i,
    input  wire logic       clr_i,
    // Results
    output logic [3:0]      status_o,
    output logic [3:0]      mask_o,
    output logic            irq_o
);
    typedef struct packed {
        logic [3:0] status;
        logic [3:0] mask;
    } hpllc_irq_t;
    hpllc_irq_t ir_reg;
    hpllc_irq_t ir_next;

    // A new event beats a read clear in the same cycle, so none is lost
    always_comb begin
        ir_next = ir_reg;
        if (ce_i) begin
            if (clr_i) ir_next.status = 4'h0;
            ir_next.status = ir_next.status | evt_i;
            if (mask_wr_i) ir_next.mask = mask_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) ir_reg <= '0;
        else ir_reg <= ir_next;
    end

    assign status_o = ir_reg.status;
    assign mask_o = ir_reg.mask;
    assign irq_o = |(ir_reg.status & ir_reg.mask);

    property p_set_wins;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && evt_i != 4'h0) |=> ((status_o & $past(evt_i)) == $past(evt_i));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    property p_clr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && clr_i && evt_i == 4'h0) |=> (status_o == 4'h0) && !irq_o;
    endproperty
    a_clr: assert property (p_clr) else $error("status not cleared by read");
endmodule

// >>> hpllc_core_model.sv
// Behavioural model of the analog PLL core that answers with a lock flag
`timescale 1ns/10ps
module hpllc_core_model #(
    parameter int LOCK_DLY = 8
)
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // Controls from the register block and from the bench
    input  wire logic pll_power_off_i,
    input  wire logic hold_rate_open_loop_i,
    input  wire logic drop_lock_i,
    // Status to the register block
    output logic      lock_o
);
    int cnt;

    // Lock only after the loop has run a while; a powered-down core never locks
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            lock_o <= 1'b0;
        end else if (pll_power_off_i || drop_lock_i) begin
            cnt <= 0;
            lock_o <= 1'b0;
        end else if (hold_rate_open_loop_i) begin
            lock_o <= lock_o;
        end else if (cnt < LOCK_DLY) begin
            cnt <= cnt + 1;
        end else begin
            lock_o <= 1'b1;
        end
    end
endmodule

// >>> tb_hpllc_top.sv
// Self-checking bench for the PLL control register block and its core model
`timescale 1ns/10ps
module tb_hpllc_top;
    import hpllc_pkg::*;
    localparam int LW = 20;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [31:0] addr_i = 32'h0;
    logic [31:0] wr_data_i = 32'h0;
    logic        wr_en_i = 1'b0;
    logic        rd_en_i = 1'b0;
    logic        drop_lock = 1'b0;
    logic [31:0] rd_data_o;
    logic        lock_i, irq_o, gate_o, pwr_o, byp_o, open_o;
    logic [3:0]  src_o, r_o, i_o;
    logic [9:0]  pre_o;
    logic [16:0] mul_o;
    logic [6:0]  post_o;
    logic [4:0]  p_o;
    int          n_fail = 0;
    int          comparisons = 0;
    int          k;
    logic [31:0] seed = 32'h50;
    logic [31:0] v, nv, ov;
    logic [31:0] mdl [logic [31:0]];
    logic [31:0] rw [8] = '{ADR_SRC, ADR_MUL, ADR_PRE, ADR_POST, ADR_R_BW, ADR_I_BW,
                            ADR_P_BW, ADR_IRQ_MK};
    logic [31:0] msk [8] = '{32'hf, 32'h1ffff, 32'h3ff, 32'h7f, 32'hf, 32'hf, 32'h1f, 32'hf};
    logic [31:0] ro [5] = '{ADR_MODE, ADR_STATE, ADR_ACK, ADR_REQ, ADR_IRQ_ST};
    logic [3:0]  codes [5] = '{SRC_FAST_OSC, SRC_MCLK_PIN, SRC_BCLK_PIN, SRC_WS_PIN, SRC_MAIN_PLL};

    hpllc_top #(.LOCK_WAIT(LW)) i_hpllc_top (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .lock_i(lock_i), .pll_input_source_o(src_o), .pre_divider_code_o(pre_o),
        .multiplier_code_o(mul_o), .post_divider_code_o(post_o), .r_bandwidth_o(r_o),
        .i_bandwidth_o(i_o), .p_bandwidth_o(p_o), .output_clock_gate_o(gate_o),
        .pll_power_off_o(pwr_o), .pre_divider_bypass_o(byp_o),
        .hold_rate_open_loop_o(open_o), .irq_o(irq_o));

    hpllc_core_model i_hpllc_core_model (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pll_power_off_i(pwr_o),
        .hold_rate_open_loop_i(open_o), .drop_lock_i(drop_lock), .lock_o(lock_i));

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Fixed-seed xorshift so every run drives the same values
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Applied code seen at the core for handshake bit j
    function automatic logic [31:0] cur(int j);
        return (j == 0) ? 32'(mul_o) : (j == 1) ? 32'(pre_o) : 32'(post_o);
    endfunction

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Single-cycle write strobe
    task automatic wr(logic [31:0] a, logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_en_i <= 1'b0;
        mdl[a] = d;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd(logic [31:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_en_i <= 1'b0;
        #1;
        d = rd_data_o;
    endtask

    // Bounded poll of the acknowledge register
    task automatic wait_ack(logic [31:0] e);
        for (int n = 0; n < 30; n++) begin
            rd(ADR_ACK, v);
            if (v === e) break;
        end
        chk("ack", v, e);
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        print_verdict();
    end

    initial begin
        foreach (rw[j]) mdl[rw[j]] = 32'h0;
        foreach (ro[j]) mdl[ro[j]] = 32'h0;
        mdl[ADR_SRC] = 32'h1;
        mdl[ADR_MODE] = 32'h4;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // Every register at its reset value
        foreach (rw[j]) begin
            rd(rw[j], v);
            chk("reset rw", v, mdl[rw[j]]);
        end
        foreach (ro[j]) begin
            rd(ro[j], v);
            chk("reset ro", v, mdl[ro[j]]);
        end
        chk("power", 32'(pwr_o), 32'h1);
        chk("gate", 32'(gate_o), 32'h0);
        // All five source encodings reach the core
        foreach (codes[j]) begin
            wr(ADR_SRC, 32'(codes[j]));
            @(negedge clk_sys_i);
            chk("source", 32'(src_o), 32'(codes[j]));
        end
        // Random codes only while powered down, so no rate limit is at stake
        repeat (14) begin
            k = 1 + int'(xs() % 7);
            wr(rw[k], xs() & msk[k]);
        end
        foreach (rw[j]) begin
            rd(rw[j], v);
            chk("readback", v, mdl[rw[j]]);
        end
        @(negedge clk_sys_i);
        chk("mul out", 32'(mul_o), mdl[ADR_MUL]);
        chk("pre out", 32'(pre_o), mdl[ADR_PRE]);
        chk("post out", 32'(post_o), mdl[ADR_POST]);
        chk("bw out", {r_o, i_o, 3'h0, p_o}, {mdl[ADR_R_BW][3:0], mdl[ADR_I_BW][3:0],
            3'h0, mdl[ADR_P_BW][4:0]});
        // Read-only and unmapped places ignore writes
        wr(ADR_STATE, 32'h3);
        wr(ADR_ACK, 32'h7);
        wr(32'h8000_4cd0, 32'h5);
        rd(ADR_STATE, v);
        chk("state ro", v, 32'h0);
        rd(ADR_ACK, v);
        chk("ack ro", v, 32'h0);
        rd(32'h8000_4cd0, v);
        chk("unmapped", v, 32'h0);
        // Mode bits reach the core
        wr(ADR_MODE, 32'h35);
        @(negedge clk_sys_i);
        chk("mode out", {gate_o, pwr_o, byp_o, open_o}, 4'hf);
        wr(ADR_IRQ_MK, 32'h1);
        wr(ADR_MODE, 32'h31);
        repeat (14) @(negedge clk_sys_i);
        rd(ADR_STATE, v);
        chk("state free", v, 32'h2);
        wr(ADR_MODE, 32'h01);
        // The core needs its lock delay plus one registered cycle
        repeat (12) @(negedge clk_sys_i);
        chk("irq lock", 32'(irq_o), 32'h1);
        rd(ADR_IRQ_ST, v);
        chk("irq status", v, 32'h1);
        @(negedge clk_sys_i);
        chk("irq clear", 32'(irq_o), 32'h0);
        rd(ADR_STATE, v);
        chk("state lock", v, 32'h1);
        // Running rate change on each handshake bit
        for (int j = 0; j < 3; j++) begin
            ov = cur(j);
            nv = (ov ^ 32'h2) & msk[j + 1];
            wr(rw[j + 1], nv);
            repeat (3) @(negedge clk_sys_i);
            chk("held code", cur(j), ov);
            wr(ADR_REQ, 32'h1 << j);
            wait_ack(32'h1 << j);
            repeat (2) @(negedge clk_sys_i);
            chk("new code", cur(j), nv);
            rd(ADR_IRQ_ST, v);
            chk("rate irq", v, 32'h4);
            wr(ADR_REQ, 32'h0);
            wait_ack(32'h0);
        end
        // A write with the clock enable low is dropped
        ov = mdl[ADR_POST];
        ce_i <= 1'b0;
        wr(ADR_POST, ov ^ 32'h1);
        ce_i <= 1'b1;
        mdl[ADR_POST] = ov;
        rd(ADR_POST, v);
        chk("ce hold", v, ov);
        // Lock lost while running closed loop times out
        wr(ADR_IRQ_MK, 32'h8);
        drop_lock <= 1'b1;
        repeat (LW + 12) @(negedge clk_sys_i);
        chk("irq tmo", 32'(irq_o), 32'h1);
        rd(ADR_IRQ_ST, v);
        chk("lost status", v, 32'ha);
        rd(ADR_STATE, v);
        chk("state unlock", v, 32'h0);
        print_verdict();
    end
endmodule
